//--- sysclk_pkg.sv
package sysclk_pkg;
	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [3:0] CLK_CTRL_OFF = 4'h0;
	localparam logic [3:0] OSC_CTRL_OFF = 4'h1;
	localparam logic [3:0] IRQ_STAT_OFF = 4'h2;
	localparam logic [3:0] IRQ_MASK_OFF = 4'h3;
	localparam int SEL_LSB = 5;
	localparam int FAST_KEEP_BIT = 1;
	localparam int SLOW_KEEP_BIT = 0;
	localparam int STABLE_BIT = 1;
	localparam int FEN_BIT = 0;
	localparam logic [2:0] SEL_RST = 3'h0;
	localparam logic KEEP_RST = 1'b0;
	localparam logic FEN_RST = 1'b1;
	localparam logic [2:0] SEL_SUB = 3'h7;
	localparam int EV_STABLE = 0;
	localparam int EV_SWITCH = 1;
	localparam int EV_W = 2;
	// ****************************************
	// Timing counts
	// ****************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam logic [2:0] DRAIN_EDGES = 3'h4;
	localparam logic [7:0] FAST_STABLE_EDGES = 8'h10;
	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;
	typedef enum logic [2:0] {MODE_RUN, MODE_SLEEP, MODE_IDLE_SLOW, MODE_IDLE_BOTH, MODE_IDLE_FAST} mode_t;
	typedef enum logic [1:0] {SW_IDLE, SW_DRAIN, SW_WAIT} sw_t;
	typedef struct packed {
		mode_t mode;
		sw_t sw;
		logic [2:0] sel;
		logic fast_keep;
		logic slow_keep;
		logic fen;
		logic stable;
		logic [7:0] stab_cnt;
		logic [2:0] act_sel;
		logic [2:0] tgt_sel;
		logic [2:0] drain_cnt;
		logic [5:0] div_cnt;
		logic fast_lvl;
		logic slow_lvl;
		logic [EV_W-1:0] stat;
		logic [EV_W-1:0] mask;
		logic [7:0] rdata;
		logic sys_clk;
		logic [6:0] fast_div;
		logic fast_on;
		logic slow_on;
		logic sub_on;
		logic cpu_run;
		logic busy;
		logic irq;
	} st_t;
endpackage

//--- sysclk_ctrl.sv
// Behaviour
// - Select code 0..6 gives fast clock divided by 2^code; code 7 gives sub clock
// - Fast clock comes only from the internal fast RC oscillator input
// - Sub clock comes from the internal slow RC oscillator input
// - Halt with both keep bits zero enters sleep; CPU, fast oscillator and sub clock stop
// - In sleep the slow oscillator runs only while the watchdog is enabled
// - Halt with fast keep 0, slow keep 1 stops CPU and fast oscillator
// - Halt with both keep bits one stops only the CPU
// - Halt with fast keep 1, slow keep 0 stops CPU and sub clock
// - In run mode with sub clock selected, fast oscillator follows its enable bit
// - Setting fast enable clears stable flag until the oscillator settles again
// - Clock switch completes in four current periods plus source alignment
// - Unused register bits read zero and ignore writes
// - Switching to the sub clock waits for slow oscillator stability
module sysclk_ctrl (
	input wire logic I_CLK,
	input wire logic I_RST_B,
	input wire sysclk_pkg::bus_req_t I_REQ,
	input wire logic I_FAST_OSC,
	input wire logic I_SLOW_OSC,
	input wire logic I_SLOW_OSC_READY,
	input wire logic I_HALT,
	input wire logic I_WAKE,
	input wire logic I_WATCHDOG_EN,
	output logic [7:0] O_RDATA,
	output logic O_SYS_CLK,
	output logic [6:0] O_FAST_DIV,
	output logic O_FAST_OSC_ON,
	output logic O_SLOW_OSC_ON,
	output logic O_SUB_CLK_ON,
	output logic O_CPU_RUN,
	output logic O_SWITCH_BUSY,
	output logic O_IRQ
);
	sysclk_pkg::st_t st_q;
	sysclk_pkg::st_t st_d;
	logic fast_rise;
	logic stab_done;
	logic tgt_lvl;
	localparam int EV_W_L = sysclk_pkg::EV_W;
	logic tgt_ok;
	logic [EV_W_L-1:0] ev;


	// ****************************************
	// Source level pick
	// ****************************************
	// Code 0 is the raw fast level, code k taps the divider, code 7 the slow level
	function automatic logic src_lvl(input logic [2:0] sel, input logic f, input logic [5:0] c, input logic s);
		logic r;
		r = f;
		if (sel == sysclk_pkg::SEL_SUB) begin
			r = s;
		end else if (sel != 3'h0) begin
			r = c[sel - 3'h1];
		end
		return r;
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_d = st_q;
		ev = '0;
		st_d.rdata = 8'h00;
		// Sample oscillators; they are the only clock sources of the block
		st_d.fast_lvl = I_FAST_OSC & st_q.fast_on;
		st_d.slow_lvl = I_SLOW_OSC & st_q.slow_on;
		fast_rise = st_d.fast_lvl & ~st_q.fast_lvl;
		if (fast_rise) begin
			st_d.div_cnt = st_q.div_cnt + 6'h01;
		end
		// Register writes; unused bit positions are simply not stored
		if (I_REQ.wr) begin
			if (I_REQ.addr == sysclk_pkg::CLK_CTRL_OFF) begin
				st_d.sel = I_REQ.wdata[sysclk_pkg::SEL_LSB +: 3];
				st_d.fast_keep = I_REQ.wdata[sysclk_pkg::FAST_KEEP_BIT];
				st_d.slow_keep = I_REQ.wdata[sysclk_pkg::SLOW_KEEP_BIT];
			end else if (I_REQ.addr == sysclk_pkg::OSC_CTRL_OFF) begin
				st_d.fen = I_REQ.wdata[sysclk_pkg::FEN_BIT];
			end else if (I_REQ.addr == sysclk_pkg::IRQ_MASK_OFF) begin
				st_d.mask = I_REQ.wdata[EV_W_L-1:0];
			end
		end
		// Stability tracking; a fresh enable restarts the settle count
		stab_done = 1'b0;
		if (!st_q.fast_on || (st_d.fen && !st_q.fen)) begin
			st_d.stable = 1'b0;
			st_d.stab_cnt = 8'h00;
		end else if (!st_q.stable && fast_rise) begin
			if (st_q.stab_cnt == sysclk_pkg::FAST_STABLE_EDGES - 8'h01) begin
				st_d.stable = 1'b1;
				stab_done = 1'b1;
			end else begin
				st_d.stab_cnt = st_q.stab_cnt + 8'h01;
			end
		end
		ev[sysclk_pkg::EV_STABLE] = stab_done;
		// Switch sequencer: drain current source, park low, catch target low
		tgt_lvl = src_lvl(st_q.tgt_sel, st_q.fast_lvl, st_q.div_cnt, st_q.slow_lvl);
		tgt_ok = (st_q.tgt_sel == sysclk_pkg::SEL_SUB) ? I_SLOW_OSC_READY : st_q.stable;
		case (st_q.sw)
			sysclk_pkg::SW_IDLE: begin
				if (st_q.sel != st_q.act_sel && st_q.mode == sysclk_pkg::MODE_RUN) begin
					st_d.sw = sysclk_pkg::SW_DRAIN;
					st_d.tgt_sel = st_q.sel;
					st_d.drain_cnt = 3'h0;
				end
			end
			sysclk_pkg::SW_DRAIN: begin
				// Counting falling edges of the output keeps the last pulse whole
				if (st_q.sys_clk && !src_lvl(st_q.act_sel, st_q.fast_lvl, st_q.div_cnt, st_q.slow_lvl)) begin
					st_d.drain_cnt = st_q.drain_cnt + 3'h1;
					if (st_q.drain_cnt == sysclk_pkg::DRAIN_EDGES - 3'h1) begin
						st_d.sw = sysclk_pkg::SW_WAIT;
					end
				end
			end
			sysclk_pkg::SW_WAIT: begin
				// Join the target only while it is low, so its next high is full
				if (!tgt_lvl && tgt_ok) begin
					st_d.sw = sysclk_pkg::SW_IDLE;
					st_d.act_sel = st_q.tgt_sel;
					ev[sysclk_pkg::EV_SWITCH] = 1'b1;
				end
			end
			default: begin
				st_d.sw = sysclk_pkg::SW_IDLE;
			end
		endcase
		// Operating mode from halt and wake
		case (st_q.mode)
			sysclk_pkg::MODE_RUN: begin
				if (I_HALT) begin
					case ({st_q.fast_keep, st_q.slow_keep})
						2'b00: st_d.mode = sysclk_pkg::MODE_SLEEP;
						2'b01: st_d.mode = sysclk_pkg::MODE_IDLE_SLOW;
						2'b11: st_d.mode = sysclk_pkg::MODE_IDLE_BOTH;
						default: st_d.mode = sysclk_pkg::MODE_IDLE_FAST;
					endcase
				end
			end
			sysclk_pkg::MODE_SLEEP, sysclk_pkg::MODE_IDLE_SLOW, sysclk_pkg::MODE_IDLE_BOTH,
				sysclk_pkg::MODE_IDLE_FAST: begin
				if (I_WAKE) begin
					st_d.mode = sysclk_pkg::MODE_RUN;
				end
			end
			default: begin
				st_d.mode = sysclk_pkg::MODE_RUN;
			end
		endcase
		// Oscillator and gate outputs follow the next mode
		case (st_d.mode)
			sysclk_pkg::MODE_RUN: begin
				// Fast source in use must run; sub selected leaves it to the enable
				st_d.fast_on = st_d.fen || st_d.act_sel != sysclk_pkg::SEL_SUB
					|| (st_d.sw != sysclk_pkg::SW_IDLE && st_d.tgt_sel != sysclk_pkg::SEL_SUB);
				st_d.slow_on = 1'b1;
				st_d.sub_on = 1'b1;
			end
			sysclk_pkg::MODE_SLEEP: begin
				st_d.fast_on = 1'b0;
				st_d.slow_on = I_WATCHDOG_EN;
				st_d.sub_on = 1'b0;
			end
			sysclk_pkg::MODE_IDLE_SLOW: begin
				st_d.fast_on = 1'b0;
				st_d.slow_on = 1'b1;
				st_d.sub_on = 1'b1;
			end
			sysclk_pkg::MODE_IDLE_BOTH: begin
				st_d.fast_on = 1'b1;
				st_d.slow_on = 1'b1;
				st_d.sub_on = 1'b1;
			end
			default: begin
				st_d.fast_on = 1'b1;
				st_d.slow_on = 1'b1;
				st_d.sub_on = 1'b0;
			end
		endcase
		st_d.cpu_run = st_d.mode == sysclk_pkg::MODE_RUN;
		// System clock is parked low while waiting and while the CPU is off
		st_d.sys_clk = st_d.cpu_run && st_q.sw != sysclk_pkg::SW_WAIT && st_d.sw != sysclk_pkg::SW_WAIT
			&& src_lvl(st_d.act_sel, st_q.fast_lvl, st_q.div_cnt, st_q.slow_lvl);
		st_d.fast_div = {st_q.div_cnt, st_q.fast_lvl};
		st_d.busy = st_d.sw != sysclk_pkg::SW_IDLE || st_d.sel != st_d.act_sel;
		// Reads; a read of status clears it, but a new event in that cycle stays
		if (I_REQ.rd) begin
			case (I_REQ.addr)
				sysclk_pkg::CLK_CTRL_OFF: begin
					st_d.rdata = {st_q.sel, 3'h0, st_q.fast_keep, st_q.slow_keep};
				end
				sysclk_pkg::OSC_CTRL_OFF: begin
					st_d.rdata = {6'h00, st_q.stable, st_q.fen};
				end
				sysclk_pkg::IRQ_STAT_OFF: begin
					st_d.rdata = {6'h00, st_q.stat};
					st_d.stat = '0;
				end
				sysclk_pkg::IRQ_MASK_OFF: begin
					st_d.rdata = {6'h00, st_q.mask};
				end
				default: begin
					st_d.rdata = 8'h00;
				end
			endcase
		end
		st_d.stat = st_d.stat | ev;
		st_d.irq = |(st_d.stat & st_d.mask);
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			st_q <= '0;
			st_q.mode <= sysclk_pkg::MODE_RUN;
			st_q.sw <= sysclk_pkg::SW_IDLE;
			st_q.sel <= sysclk_pkg::SEL_RST;
			st_q.act_sel <= sysclk_pkg::SEL_RST;
			st_q.tgt_sel <= sysclk_pkg::SEL_RST;
			st_q.fast_keep <= sysclk_pkg::KEEP_RST;
			st_q.slow_keep <= sysclk_pkg::KEEP_RST;
			st_q.fen <= sysclk_pkg::FEN_RST;
			st_q.fast_on <= 1'b1;
			st_q.slow_on <= 1'b1;
			st_q.sub_on <= 1'b1;
			st_q.cpu_run <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state register
	assign O_RDATA = st_q.rdata;
	assign O_SYS_CLK = st_q.sys_clk;
	assign O_FAST_DIV = st_q.fast_div;
	assign O_FAST_OSC_ON = st_q.fast_on;
	assign O_SLOW_OSC_ON = st_q.slow_on;
	assign O_SUB_CLK_ON = st_q.sub_on;
	assign O_CPU_RUN = st_q.cpu_run;
	assign O_SWITCH_BUSY = st_q.busy;
	assign O_IRQ = st_q.irq;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);

	property p_fast_sel;
		(st_q.cpu_run && st_q.sw == sysclk_pkg::SW_IDLE && st_q.act_sel == 3'h0 && st_d.act_sel == 3'h0
			&& st_d.cpu_run) |=> (O_SYS_CLK == $past(st_q.fast_lvl));
	endproperty
	a_fast_sel: assert property (p_fast_sel) else $error("fast select not on system clock");
	property p_sub_src;
		(st_q.cpu_run && st_q.sw == sysclk_pkg::SW_IDLE && st_q.act_sel == sysclk_pkg::SEL_SUB
			&& st_d.sw == sysclk_pkg::SW_IDLE && st_d.cpu_run) |=> (O_SYS_CLK == $past(st_q.slow_lvl));
	endproperty
	a_sub_src: assert property (p_sub_src) else $error("sub clock not on system clock");
	property p_sleep;
		(O_CPU_RUN && I_HALT && !st_q.fast_keep && !st_q.slow_keep) |=> (!O_CPU_RUN && !O_SUB_CLK_ON && !O_FAST_OSC_ON);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
	property p_watchdog;
		(st_q.mode == sysclk_pkg::MODE_SLEEP && !I_WAKE) |=> (O_SLOW_OSC_ON == $past(I_WATCHDOG_EN));
	endproperty
	a_watchdog: assert property (p_watchdog) else $error("slow oscillator ignores watchdog in sleep");
	property p_idle_slow;
		(O_CPU_RUN && I_HALT && !st_q.fast_keep && st_q.slow_keep) |=> (!O_FAST_OSC_ON && O_SUB_CLK_ON && !O_CPU_RUN);
	endproperty
	a_idle_slow: assert property (p_idle_slow) else $error("slow-only idle wrong");
	property p_idle_both;
		(O_CPU_RUN && I_HALT && st_q.fast_keep && st_q.slow_keep) |=> (O_FAST_OSC_ON && O_SUB_CLK_ON && !O_CPU_RUN);
	endproperty
	a_idle_both: assert property (p_idle_both) else $error("both-oscillator idle wrong");
	property p_idle_fast;
		(O_CPU_RUN && I_HALT && st_q.fast_keep && !st_q.slow_keep) |=> (O_FAST_OSC_ON && !O_SUB_CLK_ON && !O_SYS_CLK);
	endproperty
	a_idle_fast: assert property (p_idle_fast) else $error("fast-only idle wrong");
	property p_stable_clr;
		(I_REQ.wr && I_REQ.addr == sysclk_pkg::OSC_CTRL_OFF && I_REQ.wdata[0] && !st_q.fen) |=> !st_q.stable [*2];
	endproperty
	a_stable_clr: assert property (p_stable_clr) else $error("stable flag not cleared on enable");
	property p_park;
		(st_q.sw == sysclk_pkg::SW_WAIT) |=> !O_SYS_CLK;
	endproperty
	a_park: assert property (p_park) else $error("system clock not parked during switch");
	property p_slow_ready;
		(st_q.sw == sysclk_pkg::SW_WAIT && st_q.tgt_sel == sysclk_pkg::SEL_SUB && !I_SLOW_OSC_READY)
			|=> (st_q.sw == sysclk_pkg::SW_WAIT);
	endproperty
	a_slow_ready: assert property (p_slow_ready) else $error("switch done before slow oscillator ready");
	property p_unused;
		(I_REQ.rd && I_REQ.addr == sysclk_pkg::CLK_CTRL_OFF) |=> (O_RDATA[4:2] == 3'h0);
	endproperty
	a_unused: assert property (p_unused) else $error("unused bits read nonzero");
	c_switch: cover property ((st_q.sw == sysclk_pkg::SW_WAIT) ##1 (st_q.sw == sysclk_pkg::SW_IDLE));
	c_sleep: cover property (st_q.mode == sysclk_pkg::MODE_SLEEP ##1 I_WAKE);
	c_stable: cover property ($rose(st_q.stable));
endmodule

//--- sysclk_ctrl_test.sv
module sysclk_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Stimulus tables and signals
	// ****************************************
	typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] e;} row_t;
	typedef struct {logic [1:0] k; logic watch; logic [2:0] e; logic [2:0] m;} halt_t;
	logic I_CLK, I_RST_B, I_FAST_OSC, I_SLOW_OSC, I_SLOW_OSC_READY, I_HALT, I_WAKE, I_WATCHDOG_EN;
	sysclk_pkg::bus_req_t I_REQ;
	logic [7:0] O_RDATA;
	logic [6:0] O_FAST_DIV;
	logic O_SYS_CLK, O_FAST_OSC_ON, O_SLOW_OSC_ON, O_SUB_CLK_ON, O_CPU_RUN, O_SWITCH_BUSY, O_IRQ;
	int fail_count = 0;
	int total_checks = 0;
	int n;
	int ex;
	logic [7:0] d;
	logic [1:0] slow_div;
	// Writes then read-back; unused bits, the stable flag and an unmapped place must not stick
	row_t rows[6] = '{'{4'h0, 8'h1f, 8'h03}, '{4'h1, 8'hfd, 8'h03}, '{4'h3, 8'hff, 8'h03},
		'{4'h5, 8'hff, 8'h00}, '{4'h3, 8'h02, 8'h02}, '{4'h0, 8'h00, 8'h00}};
	// Keep bits, watchdog, expected {fast on, slow on, sub on} and which of them to compare
	halt_t hrows[5] = '{'{2'h0, 1'b1, 3'h2, 3'h7}, '{2'h0, 1'b0, 3'h0, 3'h7}, '{2'h1, 1'b0, 3'h3, 3'h7},
		'{2'h3, 1'b0, 3'h7, 3'h7}, '{2'h2, 1'b0, 3'h6, 3'h7}};

	sysclk_ctrl u_sysclk_ctrl (
		.I_CLK(I_CLK),
		.I_RST_B(I_RST_B),
		.I_REQ(I_REQ),
		.I_FAST_OSC(I_FAST_OSC),
		.I_SLOW_OSC(I_SLOW_OSC),
		.I_SLOW_OSC_READY(I_SLOW_OSC_READY),
		.I_HALT(I_HALT),
		.I_WAKE(I_WAKE),
		.I_WATCHDOG_EN(I_WATCHDOG_EN),
		.O_RDATA(O_RDATA),
		.O_SYS_CLK(O_SYS_CLK),
		.O_FAST_DIV(O_FAST_DIV),
		.O_FAST_OSC_ON(O_FAST_OSC_ON),
		.O_SLOW_OSC_ON(O_SLOW_OSC_ON),
		.O_SUB_CLK_ON(O_SUB_CLK_ON),
		.O_CPU_RUN(O_CPU_RUN),
		.O_SWITCH_BUSY(O_SWITCH_BUSY),
		.O_IRQ(O_IRQ)
	);

	// ****************************************
	// Clock and oscillator waveforms
	// ****************************************
	initial begin
		I_CLK = 1'b0;
		forever #25 I_CLK = ~I_CLK;
	end
	// Fast source period is two bus cycles, slow source eight, so every divider ratio stays visible
	always @(posedge I_CLK) begin
		I_FAST_OSC <= ~I_FAST_OSC;
		slow_div <= slow_div + 2'h1;
		if (slow_div == 2'h3) I_SLOW_OSC <= ~I_SLOW_OSC;
	end

	// ****************************************
	// Bus and checking tasks
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] w);
		@(posedge I_CLK);
		I_REQ <= '{a, w, 1'b1, 1'b0};
		@(posedge I_CLK);
		I_REQ <= '{a, 8'h00, 1'b0, 1'b0};
	endtask
	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [3:0] a, output logic [7:0] r);
		@(posedge I_CLK);
		I_REQ <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge I_CLK);
		I_REQ <= '{a, 8'h00, 1'b0, 1'b0};
		#1 r = O_RDATA;
	endtask
	// Bounded wait for the switch to finish; a hung switch counts as a mismatch
	task automatic settle(input int lim);
		repeat (2) @(posedge I_CLK);
		#1 n = 0;
		while (O_SWITCH_BUSY !== 1'b0 && n < lim) begin
			@(posedge I_CLK);
			#1 n++;
		end
		if (n >= lim) chk(8'h01, 8'h00, "switch not finished in time");
	endtask
	task automatic count_rises(input int cyc, output int c);
		logic p;
		c = 0;
		p = O_SYS_CLK;
		repeat (cyc) begin
			@(posedge I_CLK);
			#1 if (O_SYS_CLK === 1'b1 && p === 1'b0) c++;
			p = O_SYS_CLK;
		end
	endtask
	// Same span and sampling as above, on one tap of the peripheral divider
	task automatic count_div(input int b, input int cyc, output int c);
		logic p;
		c = 0;
		p = O_FAST_DIV[b];
		repeat (cyc) begin
			@(posedge I_CLK);
			#1 if (O_FAST_DIV[b] === 1'b1 && p === 1'b0) c++;
			p = O_FAST_DIV[b];
		end
	endtask
	task automatic pulse(input logic halt);
		@(posedge I_CLK);
		if (halt) I_HALT <= 1'b1; else I_WAKE <= 1'b1;
		@(posedge I_CLK);
		I_HALT <= 1'b0;
		I_WAKE <= 1'b0;
		repeat (2) @(posedge I_CLK);
		#1;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Watchdog sized well beyond the longest expected run
	initial begin
		#(50 * 30000);
		fail_count++;
		$display("mismatch at %0t: run did not complete", $time);
		wrap_up();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		I_RST_B = 1'b0;
		I_REQ = '0;
		I_FAST_OSC = 1'b0;
		I_SLOW_OSC = 1'b0;
		I_SLOW_OSC_READY = 1'b0;
		I_HALT = 1'b0;
		I_WAKE = 1'b0;
		I_WATCHDOG_EN = 1'b0;
		slow_div = 2'h0;
		repeat (3) @(posedge I_CLK);
		I_RST_B <= 1'b1;
		rd(4'h0, d); chk(d, 8'h00, "clock control reset");
		rd(4'h1, d); chk(d, 8'h01, "fast control reset");
		repeat (40) @(posedge I_CLK);
		rd(4'h1, d); chk(d, 8'h03, "stable flag set");
		rd(4'h2, d); chk(d, 8'h01, "stable event");
		chk({7'h0, O_IRQ}, 8'h00, "irq while masked");
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, d); chk(d, rows[i].e, "register readback");
		end
		$display("test registers done");
		// Move to the sub clock; the switch must hold off until the slow source is ready
		wr(4'h0, 8'he0);
		repeat (60) @(posedge I_CLK);
		#1 chk({7'h0, O_SWITCH_BUSY}, 8'h01, "switch before slow ready");
		@(posedge I_CLK);
		I_SLOW_OSC_READY <= 1'b1;
		settle(64);
		chk({7'h0, O_IRQ}, 8'h01, "irq on switch done");
		rd(4'h2, d); chk(d, 8'h02, "switch done event");
		chk({7'h0, O_IRQ}, 8'h00, "irq after status read");
		$display("test sub switch done");
		// Fast source obeys its enable while the sub clock runs the system
		wr(4'h1, 8'h00);
		repeat (2) @(posedge I_CLK);
		#1 chk({7'h0, O_FAST_OSC_ON}, 8'h00, "fast off in slow mode");
		wr(4'h1, 8'h01);
		rd(4'h1, d); chk(d, 8'h01, "stable cleared on enable");
		chk({7'h0, O_FAST_OSC_ON}, 8'h01, "fast on in slow mode");
		repeat (40) @(posedge I_CLK);
		rd(4'h1, d); chk(d, 8'h03, "stable after restart");
		chk({7'h0, O_IRQ}, 8'h00, "masked stable event");
		rd(4'h2, d); chk(d, 8'h01, "stable event again");
		$display("test fast enable done");
		// Every select code, counting system clock rises over a fixed span
		for (int k = 0; k < 8; k++) begin
			wr(4'h0, {k[2:0], 5'h00});
			settle((k == 0) ? 64 : 1000);
			count_rises(256, n);
			ex = (k == 7) ? 32 : (128 >> k);
			chk({7'h0, (n >= ex - 1 && n <= ex + 1)}, 8'h01, "system clock rate");
		end
		wr(4'h0, 8'h00);
		settle(1000);
		// Peripheral taps: tap k carries the fast clock divided by 2^k
		for (int k = 0; k < 7; k++) begin
			count_div(k, 256, n);
			ex = 128 >> k;
			chk({7'h0, (n >= ex - 1 && n <= ex + 1)}, 8'h01, "fast divider tap rate");
		end
		$display("test divider done");
		// Each halt flavour, then wake
		foreach (hrows[i]) begin
			wr(4'h0, {6'h00, hrows[i].k});
			I_WATCHDOG_EN <= hrows[i].watch;
			pulse(1'b1);
			chk({7'h0, O_CPU_RUN}, 8'h00, "cpu stopped");
			chk({5'h0, {O_FAST_OSC_ON, O_SLOW_OSC_ON, O_SUB_CLK_ON} & hrows[i].m},
				{5'h0, hrows[i].e & hrows[i].m}, "halt clocks");
			pulse(1'b0);
			chk({7'h0, O_CPU_RUN}, 8'h01, "cpu resumed");
		end
		$display("test halt done");
		// Reset again in mid-run
		wr(4'h0, 8'h03);
		@(posedge I_CLK);
		I_RST_B <= 1'b0;
		repeat (3) @(posedge I_CLK);
		I_RST_B <= 1'b1;
		rd(4'h0, d); chk(d, 8'h00, "clock control after reset");
		$display("test second reset done");
		wrap_up();
	end
endmodule
